// [pdp_dp_defines.vh]
// Constant definitions shared by the processor data path.
`ifndef DPTH_DEFINES_VH
`define DPTH_DEFINES_VH
`define DP_DSEL_RESULT 2'h0
`define DP_DSEL_BUS 2'h1
`define DP_DSEL_SHIFT 2'h2
`define DP_DSEL_READBUS 2'h3
`define DP_CSEL_WORD 2'h0
`define DP_CSEL_BYTE 2'h1
`define DP_CSEL_STATUS 2'h2
`define DP_CSEL_ALU15 2'h3
`define DP_ASEL_ALU 1'h0
`define DP_ASEL_READBUS 1'h1
`define DP_BSEL_MDATA 2'h0
`define DP_BSEL_BREG 2'h1
`define DP_BSEL_ZERO 2'h2
`define DP_BSEL_ONE 2'h3
`define DP_RELOC_LO 6
`define DP_RELOC_HI 15
`define DP_HIADDR_LO 13
`define DP_STACK_LIMIT 16'h0100
`define DP_MATCH_BITS 9
`endif

// [pdp_dp_slice.v]
// Four-bit ALU slice with generate and propagate outputs for lookahead.
`timescale 1ns/1ps
module dpth_slice (
	// Operands and operation
	input wire [3:0] i_a,
	input wire [3:0] i_b,
	input wire [2:0] i_op,
	input wire i_cin,
	// Results
	output reg [3:0] o_f,
	output wire o_g,
	output wire o_p
);
	wire [3:0] bx;
	wire [3:0] gen;
	wire [3:0] prop;
	wire [4:0] c;
	genvar k;
	// Op 1 subtracts by inverting B; the caller supplies carry-in one.
	assign bx = (i_op == 3'h1) ? ~i_b : i_b;
	assign gen = i_a & bx;
	assign prop = i_a ^ bx;
	assign c[0] = i_cin;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_c
			assign c[k + 1] = gen[k] | (prop[k] & c[k]);
		end
	endgenerate
	assign o_g = gen[3] | (prop[3] & gen[2]) | (prop[3] & prop[2] & gen[1])
		| (prop[3] & prop[2] & prop[1] & gen[0]);
	assign o_p = (i_op == 3'h0 || i_op == 3'h1) ? &prop : 1'b0;
	always @* begin
		case (i_op)
			3'h0: o_f = prop ^ c[3:0];
			3'h1: o_f = prop ^ c[3:0];
			3'h2: o_f = i_a & i_b;
			3'h3: o_f = i_a | i_b;
			3'h4: o_f = i_a ^ i_b;
			3'h5: o_f = i_a & ~i_b;
			3'h6: o_f = i_a;
			default: o_f = i_b;
		endcase
	end
endmodule

// [pdp_dp_top.v]
// Sixteen-bit processor data path with result, address and carry registers.
//
// Operation
// - Main data mux picks result, bus data, shifted result or read bus.
// - Main data mux feeds B register and all processor register writes.
// - Result register holds ALU data for bus cycles and scratch writeback.
// - Result and other data registers have no clear; undefined until loaded.
// - Result drives bus data only while drive-data enable is asserted.
// - Address mux loads address register from ALU or read bus.
// - Carry flop input picks word carry, byte carry, status carry, ALU bit 15.
// - Rotate right feeds carry into main mux; result bit 0 is new carry under ALU bit 15 carry select.
// - ALU uses lookahead across slices and outputs every fourth carry.
// - ALU A and B bits 15 and 7 go to overflow logic.
// - Result bit 7 is the byte sign for condition codes.
// - Without relocation, address bits 16,17 set when bits 15..13 all set.
// - Address register drives bus address only under drive-address enable.
// - Relocation strap disables drivers for address bits 15 to 6 and upper bits 17,16.
// - Internal register addresses decode from the address register only.
// - Address register also decoded for protected low memory stack check.
// - Result decoded into low byte zero and full word zero.
// - Address register bits 3..0 offered as scratch pad select source.
// - Address bit 0 offered for odd byte and byte branch decisions.
// - B register bit 15 feeds B select and byte swap path.
// - Console shows main mux; switches compared to microaddress pointer.
// - Switch match is a level while switches 8..0 equal pointer.
`timescale 1ns/1ps
`include "pdp_dp_defines.vh"
module dpth_top #(
	parameter W = 16,
	parameter MB = `DP_MATCH_BITS,
	parameter [W-1:0] INT_BASE = 16'hff00,
	parameter [W-1:0] INT_MASK = 16'hff00,
	parameter [W-1:0] STACK_LIMIT = `DP_STACK_LIMIT
) (
	// Clock, enable and reset
	input wire i_mclk,
	input wire i_ce,
	input wire i_arst_n,
	// Microcontrol selects and load strobes
	input wire [1:0] i_main_data_mux,
	input wire i_address_source_mux,
	input wire [1:0] i_alu_b_select,
	input wire [1:0] i_carry_select_mux,
	input wire [2:0] i_alu_op,
	input wire i_alu_cin,
	input wire i_swap_byte,
	input wire i_load_b,
	input wire i_load_result,
	input wire i_load_addr,
	input wire i_drive_data_enable,
	input wire i_drive_address_enable,
	input wire i_relocation_strap,
	// Data sources
	input wire [W-1:0] i_bus_data,
	input wire [W-1:0] i_read_bus,
	input wire i_status_carry_bit,
	// Console
	input wire [MB-1:0] i_console_switches,
	input wire [MB-1:0] i_microaddress_pointer,
	// Bus drive
	output reg [W-1:0] o_bus_data,
	output reg o_bus_data_oe,
	output reg [17:0] o_bus_addr,
	output reg [17:0] o_bus_addr_oe,
	// Register write path and decodes
	output reg [W-1:0] o_reg_wdata,
	output reg [3:0] o_addr_reg_select,
	output reg o_addr_odd,
	output reg o_internal_addr,
	output reg o_stack_low,
	output reg o_zero_word,
	output reg o_zero_byte,
	output reg o_byte_sign,
	output reg o_result_carry,
	output reg [3:0] o_slice_carry,
	output reg [3:0] o_ovf_bits,
	output reg o_b15,
	output reg [W-1:0] o_console_display,
	output reg o_switch_match
);
	reg [W-1:0] result_r;
	reg [W-1:0] b_r;
	reg [W-1:0] addr_r;
	reg carry_r;
	reg [W-1:0] mdata;
	reg [W-1:0] alu_b;
	reg carry_nxt;
	wire [W-1:0] alu_f;
	wire [3:0] sg;
	wire [3:0] sp;
	wire [4:0] sc;
	wire [W-1:0] addr_nxt;
	wire [W-1:0] swapped_b;
	reg [17:0] bus_addr_nxt;
	reg [17:0] bus_addr_oe_nxt;
	reg internal_nxt;
	reg stack_low_nxt;
	reg zero_word_nxt;
	reg zero_byte_nxt;
	reg switch_match_nxt;
	reg [3:0] ovf_nxt;
	reg high_pair;
	reg reloc_drive;
	genvar s;

	// main data mux; carry enters on rotate right.
	always @* begin
		case (i_main_data_mux)
			`DP_DSEL_RESULT: mdata = result_r;
			`DP_DSEL_BUS: mdata = i_bus_data;
			`DP_DSEL_SHIFT: mdata = {carry_r, result_r[W-1:1]};
			`DP_DSEL_READBUS: mdata = i_read_bus;
			default: mdata = result_r;
		endcase
	end

	// byte swap path takes B register, including bit 15.
	assign swapped_b = {b_r[7:0], b_r[W-1:8]};

	// B select with B register feedback.
	always @* begin
		case (i_alu_b_select)
			`DP_BSEL_MDATA: alu_b = mdata;
			`DP_BSEL_BREG: alu_b = i_swap_byte ? swapped_b : b_r;
			`DP_BSEL_ZERO: alu_b = {W{1'b0}};
			`DP_BSEL_ONE: alu_b = {{(W-1){1'b0}}, 1'b1};
			default: alu_b = b_r;
		endcase
	end

	assign sc[0] = i_alu_cin;
	generate
		for (s = 0; s < 4; s = s + 1) begin : g_slice
			dpth_slice u_slice (
				.i_a(i_read_bus[4*s+3:4*s]),
				.i_b(alu_b[4*s+3:4*s]),
				.i_op(i_alu_op),
				.i_cin(sc[s]),
				.o_f(alu_f[4*s+3:4*s]),
				.o_g(sg[s]),
				.o_p(sp[s])
			);
			assign sc[s + 1] = sg[s] | (sp[s] & sc[s]);
		end
	endgenerate

	// carry select; rotate right takes result bit 0 in place of ALU bit 15 on the ALU15 select.
	always @* begin
		case (i_carry_select_mux)
			`DP_CSEL_WORD: carry_nxt = sc[4];
			`DP_CSEL_BYTE: carry_nxt = sc[2];
			`DP_CSEL_STATUS: carry_nxt = i_status_carry_bit;
			`DP_CSEL_ALU15: carry_nxt = (i_main_data_mux == `DP_DSEL_SHIFT) ?
				result_r[0] : alu_f[W-1];
			default: carry_nxt = sc[4];
		endcase
	end

	assign addr_nxt = (i_address_source_mux == `DP_ASEL_READBUS) ? i_read_bus : alu_f;

	// data registers carry no reset: contents undefined until loaded.
	always @(posedge i_mclk) begin
		if (i_ce) begin
			if (i_load_b) begin
				b_r <= mdata;
			end
			if (i_load_result) begin
				result_r <= alu_f;
				carry_r <= carry_nxt;
			end
			if (i_load_addr) begin
				addr_r <= addr_nxt;
			end
		end
	end

	// upper address pair from bits 15..13.
	always @* begin
		high_pair = &addr_r[W-1:`DP_HIADDR_LO];
		bus_addr_nxt = {{2{high_pair}}, addr_r};
	end

	// strap releases bits 15..6 and the upper pair to the option.
	always @* begin
		reloc_drive = i_drive_address_enable & ~i_relocation_strap;
		bus_addr_oe_nxt = {{2{reloc_drive}},
			{(`DP_RELOC_HI-`DP_RELOC_LO+1){reloc_drive}},
			{`DP_RELOC_LO{i_drive_address_enable}}};
	end

	// internal register decode.
	// The compare uses the register, not the bus lines, so no peripheral can hit it.
	always @* begin
		internal_nxt = ((addr_r & INT_MASK) == INT_BASE);
		stack_low_nxt = (addr_r < STACK_LIMIT);
	end

	always @* begin
		zero_word_nxt = (result_r == {W{1'b0}});
		zero_byte_nxt = (result_r[7:0] == 8'h00);
	end

	always @* begin
		ovf_nxt = {i_read_bus[15], alu_b[15], i_read_bus[7], alu_b[7]};
	end

	always @* begin
		switch_match_nxt = ~|(i_console_switches ^ i_microaddress_pointer);
	end

	// Outputs are flops with reset so the pins are defined while the data registers are not.
	// bus drive flops.
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_bus_data <= 16'h0000;
			o_bus_data_oe <= 1'b0;
			o_bus_addr <= 18'h00000;
			o_bus_addr_oe <= 18'h00000;
		end else if (i_ce) begin
			o_bus_data <= result_r;
			o_bus_data_oe <= i_drive_data_enable;
			o_bus_addr <= bus_addr_nxt;
			o_bus_addr_oe <= bus_addr_oe_nxt;
		end
	end

	// write data and address register decodes.
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reg_wdata <= 16'h0000;
			o_addr_reg_select <= 4'h0;
			o_addr_odd <= 1'b0;
			o_internal_addr <= 1'b0;
			o_stack_low <= 1'b0;
		end else if (i_ce) begin
			// write data for scratch pad and status registers.
			o_reg_wdata <= mdata;
			o_addr_reg_select <= addr_r[3:0];
			o_addr_odd <= addr_r[0];
			o_internal_addr <= internal_nxt;
			o_stack_low <= stack_low_nxt;
		end
	end

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_zero_word <= 1'b0;
			o_zero_byte <= 1'b0;
			o_byte_sign <= 1'b0;
			o_result_carry <= 1'b0;
		end else if (i_ce) begin
			o_zero_word <= zero_word_nxt;
			o_zero_byte <= zero_byte_nxt;
			o_byte_sign <= result_r[7];
			o_result_carry <= carry_r;
		end
	end

	// ALU taps for the status logic.
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_slice_carry <= 4'h0;
			o_ovf_bits <= 4'h0;
			o_b15 <= 1'b0;
		end else if (i_ce) begin
			o_slice_carry <= sc[4:1];
			o_ovf_bits <= ovf_nxt;
			o_b15 <= b_r[W-1];
		end
	end

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_console_display <= 16'h0000;
			o_switch_match <= 1'b0;
		end else if (i_ce) begin
			o_console_display <= mdata;
			o_switch_match <= switch_match_nxt;
		end
	end
endmodule

// [dpth_properties.sv]
// Port checker for the data path, bound to its top module.
`timescale 1ns/1ps
module dpth_chk #(parameter W = 16, parameter MB = 9) (
	input wire i_mclk, i_arst_n, i_ce, i_load_result, i_load_addr, i_address_source_mux,
	input wire i_alu_cin, i_drive_data_enable, i_drive_address_enable, i_relocation_strap,
	input wire [1:0] i_main_data_mux, i_alu_b_select,
	input wire [2:0] i_alu_op,
	input wire [W-1:0] i_read_bus, o_bus_data, o_reg_wdata, o_console_display,
	input wire [MB-1:0] i_console_switches, i_microaddress_pointer,
	input wire [17:0] o_bus_addr, o_bus_addr_oe,
	input wire [3:0] o_ovf_bits, o_slice_carry,
	input wire o_bus_data_oe, o_switch_match
);
	reg ok_r;
	// Set only when the previous edge was enabled and out of reset.
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) ok_r <= 1'b0;
		else ok_r <= i_ce;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	sequence s_res_ld; i_ce && i_load_result && i_alu_op == 3'h6 ##1 i_ce; endsequence
	sequence s_adr_ld; i_ce && i_load_addr && i_address_source_mux ##1 i_ce; endsequence
	sequence s_add_zero;
		ok_r && $past(i_alu_op) == 3'h0 && $past(i_alu_b_select) == 2'h2 && !$past(i_alu_cin);
	endsequence
	a_result_bus: assert property (s_res_ld |=> o_bus_data == $past(i_read_bus, 2))
		else $error("bus data differs from loaded result");
	a_addr_load: assert property (s_adr_ld |=> o_bus_addr[15:0] == $past(i_read_bus, 2))
		else $error("bus address differs from loaded value");
	a_addr_high: assert property (s_adr_ld |=> o_bus_addr[17:16] == {2{&o_bus_addr[15:13]}})
		else $error("upper address bits wrong");
	a_data_oe: assert property (ok_r |-> o_bus_data_oe == $past(i_drive_data_enable))
		else $error("data drive enable wrong");
	a_addr_oe: assert property (ok_r |-> o_bus_addr_oe == {{12{$past(i_drive_address_enable)
		&& !$past(i_relocation_strap)}}, {6{$past(i_drive_address_enable)}}})
		else $error("address drive enables wrong");
	a_switch_match: assert property (ok_r |-> o_switch_match ==
		($past(i_console_switches) == $past(i_microaddress_pointer)))
		else $error("switch match wrong");
	a_display_mux: assert property (ok_r && $past(i_main_data_mux) == 2'h3 |->
		o_console_display == $past(i_read_bus) && o_reg_wdata == o_console_display)
		else $error("display or write data wrong");
	a_ovf_one: assert property (ok_r && $past(i_alu_b_select) == 2'h3 |-> o_ovf_bits ==
		{$past(i_read_bus[15]), 1'b0, $past(i_read_bus[7]), 1'b0})
		else $error("overflow bits wrong");
	a_carry_none: assert property (s_add_zero |-> o_slice_carry == 4'h0)
		else $error("slice carry without cause");
	a_hold_freeze: assert property (!i_ce |=> $stable(o_bus_data) && $stable(o_reg_wdata))
		else $error("output moved while disabled");
endmodule
bind dpth_top dpth_chk #(.W(W), .MB(MB)) u_chk (.i_mclk, .i_arst_n, .i_ce, .i_load_result,
	.i_load_addr, .i_address_source_mux, .i_alu_cin, .i_drive_data_enable,
	.i_drive_address_enable, .i_relocation_strap, .i_main_data_mux, .i_alu_b_select, .i_alu_op,
	.i_read_bus, .o_bus_data, .o_reg_wdata, .o_console_display, .i_console_switches,
	.i_microaddress_pointer, .o_bus_addr, .o_bus_addr_oe, .o_ovf_bits, .o_slice_carry,
	.o_bus_data_oe, .o_switch_match);

// [dpth_bus.sv]
// System bus model: small memory behind the processor's bus drivers.
`timescale 1ns/1ps
module dpth_bus (
	input wire i_mclk,
	input wire [15:0] i_data,
	input wire i_data_oe,
	input wire [17:0] i_addr,
	input wire i_addr_oe,
	output reg [15:0] o_line
);
	reg [15:0] mem [0:15];
	reg [15:0] last_r = 16'h0000;
	always @(posedge i_mclk) begin
		if (i_data_oe && i_addr_oe) mem[i_addr[3:0]] <= i_data;
		last_r <= o_line;
	end
	// A released bus keeps changing so a stale value never passes for data.
	always @* begin
		if (i_data_oe) o_line = i_data;
		else if (i_addr_oe) o_line = mem[i_addr[3:0]];
		else o_line = ~last_r;
	end
endmodule

// [testbench.sv]
// Self-checking bench for the data path with a bus model.
`timescale 1ns/1ps
`include "pdp_dp_defines.vh"
module testbench;
	reg i_mclk = 0, i_ce = 1, i_arst_n = 0, i_address_source_mux = 0, i_alu_cin = 0;
	reg i_swap_byte = 0, i_load_b = 0, i_load_result = 0, i_load_addr = 0;
	reg i_drive_data_enable = 0, i_drive_address_enable = 0, i_relocation_strap = 0;
	reg i_status_carry_bit = 0;
	reg [1:0] i_main_data_mux = 0, i_alu_b_select = 0, i_carry_select_mux = 0;
	reg [2:0] i_alu_op = 0;
	reg [15:0] i_read_bus = 0, v, s;
	reg [8:0] i_console_switches = 0, i_microaddress_pointer = 0;
	reg [17:0] e;
	wire [15:0] i_bus_data, o_bus_data, o_reg_wdata, o_console_display;
	wire [17:0] o_bus_addr, o_bus_addr_oe;
	wire [3:0] o_addr_reg_select, o_slice_carry, o_ovf_bits;
	wire o_bus_data_oe, o_addr_odd, o_internal_addr, o_stack_low, o_zero_word, o_zero_byte;
	wire o_byte_sign, o_result_carry, o_b15, o_switch_match;
	integer n_fail = 0, checks = 0, i;
	dpth_top u_dut (.i_mclk, .i_ce, .i_arst_n, .i_main_data_mux, .i_address_source_mux,
		.i_alu_b_select, .i_carry_select_mux, .i_alu_op, .i_alu_cin, .i_swap_byte, .i_load_b,
		.i_load_result, .i_load_addr, .i_drive_data_enable, .i_drive_address_enable,
		.i_relocation_strap, .i_bus_data, .i_read_bus, .i_status_carry_bit, .i_console_switches,
		.i_microaddress_pointer, .o_bus_data, .o_bus_data_oe, .o_bus_addr, .o_bus_addr_oe,
		.o_reg_wdata, .o_addr_reg_select, .o_addr_odd, .o_internal_addr, .o_stack_low,
		.o_zero_word, .o_zero_byte, .o_byte_sign, .o_result_carry, .o_slice_carry, .o_ovf_bits,
		.o_b15, .o_console_display, .o_switch_match);
	dpth_bus u_bus (.i_mclk, .i_data(o_bus_data), .i_data_oe(o_bus_data_oe),
		.i_addr(o_bus_addr), .i_addr_oe(o_bus_addr_oe[0]), .o_line(i_bus_data));
	initial forever #50 i_mclk = ~i_mclk;
	function [3:0] slc(input [15:0] a, input [15:0] c);
		integer j;
		reg [16:0] t;
		for (j = 0; j < 4; j = j + 1) begin
			t = (a & ((17'h1 << (4 * j + 4)) - 1)) + (c & ((17'h1 << (4 * j + 4)) - 1));
			slc[j] = t[4 * j + 4];
		end
	endfunction
	// Sum with carries out of bit 15 and bit 7: {carry15, carry7, sum}.
	function [17:0] addx(input [15:0] a, input [15:0] b, input c);
		reg [8:0] lo;
		reg [16:0] full;
		begin
			lo = a[7:0] + b[7:0] + c;
			full = a + b + c;
			addx = {full[16], lo[8], full[15:0]};
		end
	endfunction
	task chk(input [17:0] got, input [17:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task step;
		begin
			@(posedge i_mclk);
			@(negedge i_mclk);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d n_fail %0d", checks, n_fail);
			if (n_fail == 0 && checks > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		#1000000;
		n_fail = n_fail + 1;
		final_report;
	end
	initial begin
		s = $urandom(32'h27c65110);
		repeat (20) @(negedge i_mclk);
		i_arst_n = 1;
		for (i = 0; i < 40; i = i + 1) begin
			s = $urandom;
			v = (i < 8) ? {i[1] ? 8'hff : 8'h00, i[0] ? 8'hff : 8'h00} ^ {7'h0, i[2], 8'h0} : $urandom;
			i_read_bus = v;
			{i_load_result, i_load_addr, i_drive_data_enable, i_drive_address_enable} = 4'hf;
			{i_alu_op, i_address_source_mux, i_main_data_mux} = {3'h6, `DP_ASEL_READBUS, `DP_DSEL_READBUS};
			{i_carry_select_mux, i_alu_b_select, i_relocation_strap} = {`DP_CSEL_ALU15, 1'b1, s[0], s[1]};
			{i_console_switches, i_microaddress_pointer} = {v[8:0], s[2] ? v[8:0] : s[11:3]};
			i_status_carry_bit = s[12];
			step;
			{i_load_result, i_load_addr, i_alu_op, i_main_data_mux} = {5'h0, `DP_DSEL_SHIFT};
			step;
			chk(o_bus_data, v);
			chk(o_bus_addr, {{2{&v[15:13]}}, v});
			chk(o_bus_addr_oe, {{12{~s[1]}}, 6'h3f});
			chk({o_bus_data_oe, o_zero_word, o_zero_byte, o_byte_sign, o_addr_odd},
				{1'b1, v == 16'h0, v[7:0] == 8'h0, v[7], v[0]});
			chk({o_addr_reg_select, o_internal_addr, o_stack_low},
				{v[3:0], v[15:8] == 8'hff, v < `DP_STACK_LIMIT});
			chk(o_reg_wdata, {v[15], v[15:1]});
			chk(o_result_carry, v[15]);
			chk(o_slice_carry, slc(v, {15'h0, s[0]}));
			chk(o_ovf_bits, {v[15], 1'b0, v[7], 1'b0});
			chk(o_switch_match, i_console_switches == i_microaddress_pointer);
			{i_load_result, i_alu_op} = 4'he;
			step;
			{i_load_result, i_main_data_mux} = {1'b0, `DP_DSEL_BUS};
			{i_drive_data_enable, i_drive_address_enable} = s[14:13];
			step;
			chk(o_result_carry, v[0]);
			chk(o_console_display, v);
			{i_ce, i_main_data_mux, i_read_bus} = {1'b0, `DP_DSEL_READBUS, ~v};
			step;
			chk(o_console_display, v);
			chk({o_bus_data_oe, o_bus_addr_oe[0]}, s[14:13]);
			i_ce = 1;
			{i_load_b, i_load_result, i_carry_select_mux, i_alu_op} = {2'h3, `DP_CSEL_STATUS, 3'h6};
			step;
			{i_load_b, i_alu_b_select, i_swap_byte, i_alu_cin} = {1'b0, `DP_BSEL_BREG, s[15], s[4]};
			{i_carry_select_mux, i_alu_op} = {s[5] ? `DP_CSEL_BYTE : `DP_CSEL_WORD, 2'h0, s[6]};
			step;
			chk(o_b15, !v[15]);
			chk(o_result_carry, s[12]);
			e = addx(~v, (s[15] ? {~v[7:0], ~v[15:8]} : ~v) ^ {16{s[6]}}, s[4]);
			{i_load_result, i_alu_cin} = 2'h0;
			step;
			chk(o_bus_data, e[15:0]);
			chk(o_result_carry, s[5] ? e[16] : e[17]);
		end
		final_report;
	end
endmodule
